// ### logic/tbo_bus_own.sv
/*
 tbo_bus_own: processor side of the three-wire bus ownership scheme plus
 memory control and acknowledge for external master transfers.
 Assumes all inputs but i_reset_n synchronous to i_sys_clk; the ack pin wire is resolved
 outside from o_xfer_ack_n and o_xfer_ack_oe.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tbo_cfg.svh"
module tbo_bus_own (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_reset_n,
	input  wire logic                    i_hard_reset_in,
	input  wire logic                    i_wdog_reset,
	input  wire logic                    i_bus_grant_in,
	input  wire tbo_pkg::tbo_core_t      i_core,
	input  wire logic                    i_upper_addr_en,
	input  wire logic                    i_xfer_begin_strobe,
	input  wire tbo_pkg::tbo_cap_t       i_xfer,
	input  wire logic                    i_xfer_ack_n_in,
	input  wire tbo_pkg::tbo_cs_cfg_t    i_chip_sel_ctrl [`TBO_NUM_CS],
	input  wire tbo_pkg::tbo_dram_cfg_t  i_dram_ctrl_cfg [`TBO_NUM_DRAM],
	input  wire tbo_pkg::tbo_def_mem_t   i_default_mem_ctrl,
	output logic                         o_bus_driven_out,
	output logic                         o_bus_request_out,
	output logic                         o_bus_owner,
	output logic                         o_xfer_start_ok,
	output tbo_pkg::tbo_mem_t            o_mem,
	output logic                         o_xfer_ack_n,
	output logic                         o_xfer_ack_oe
);
	localparam tbo_pkg::tbo_state_t RST_STATE = '{
		own: tbo_pkg::OWN_RESET, bus_driven_out: 1'b0, bus_request_out: 1'b0,
		owner: 1'b0, start_ok: 1'b0, em: tbo_pkg::EM_IDLE, cap: '0, cnt: '0,
		auto_ack: 1'b0,
		mem: '{cs_n: `TBO_RST_CS_N, we_n: `TBO_RST_LANE_N, ras_n: `TBO_RST_RAS_N,
			cas_n: `TBO_RST_LANE_N, dram_write_n: 1'b1, dram_addr_oe: 1'b0},
		ack_n: 1'b1, ack_oe: 1'b0};

	logic                             rst_meta;
	logic                             rst_n;
	logic                             resets;
	tbo_pkg::tbo_state_t              st;
	tbo_pkg::tbo_state_t              next_st;
	logic [`TBO_NUM_CS-1:0]           cs_sel;
	logic [`TBO_NUM_DRAM-1:0]         dram_sel;
	logic                             in_region;
	logic                             dec_auto;
	logic                             dec_drive;
	logic [`TBO_WAIT_W-1:0]           dec_wait;
	logic [`TBO_NUM_LANES-1:0]        lanes;

	// byte lanes of the captured transfer, lane 3 is address offset 0
	// aligned only
	function automatic logic [`TBO_NUM_LANES-1:0] lanes_of(input logic [1:0] sz, input logic [1:0] a);
		logic [`TBO_NUM_LANES-1:0] l;
		l = 4'hF;
		if (sz == `TBO_SIZE_BYTE)
			l = 4'h8 >> a;
		else if (sz == `TBO_SIZE_WORD)
			l = a[1] ? 4'h3 : 4'hC;
		return l;
	endfunction

	// reset released through two flops so every state flop leaves reset together
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	tbo_addr_decode #(
		.NUM_CS   (`TBO_NUM_CS),
		.NUM_DRAM (`TBO_NUM_DRAM)
	) u_decode (
		.i_cap              (st.cap),
		.i_chip_sel_ctrl    (i_chip_sel_ctrl),
		.i_dram_ctrl_cfg    (i_dram_ctrl_cfg),
		.i_default_mem_ctrl (i_default_mem_ctrl),
		.o_cs_sel           (cs_sel),
		.o_dram_sel         (dram_sel),
		.o_in_region        (in_region),
		.o_auto_ack         (dec_auto),
		.o_dram_drive       (dec_drive),
		.o_wait             (dec_wait)
	);

	assign resets = i_hard_reset_in || i_wdog_reset;
	assign lanes  = lanes_of(st.cap.xfer_size, st.cap.addr[1:0]);

	// next state of ownership and of the external master sequence
	always_comb begin
		next_st = st;
		if (resets) begin
			next_st.own = tbo_pkg::OWN_RESET;
		end else begin
			case (st.own)
				tbo_pkg::OWN_RESET: next_st.own = i_bus_grant_in ? tbo_pkg::OWN_IMPLICIT : tbo_pkg::OWN_EM;
				tbo_pkg::OWN_IMPLICIT, tbo_pkg::OWN_EM: begin
					if (!i_bus_grant_in)
						next_st.own = tbo_pkg::OWN_EM;
					else if (i_core.bus_lock || i_core.core_bus_need)
						next_st.own = tbo_pkg::OWN_EXPLICIT;
					else
						next_st.own = tbo_pkg::OWN_IMPLICIT;
				end
				tbo_pkg::OWN_EXPLICIT: begin
					if (!i_bus_grant_in && !i_core.bus_lock
						&& (!i_core.cycle_busy || i_core.cycle_end))
						next_st.own = tbo_pkg::OWN_EM;
				end
				default: next_st.own = tbo_pkg::OWN_RESET;
			endcase
		end
		next_st.bus_driven_out = (next_st.own == tbo_pkg::OWN_EXPLICIT);
		next_st.owner = (next_st.own == tbo_pkg::OWN_EXPLICIT) || (next_st.own == tbo_pkg::OWN_IMPLICIT);
		next_st.start_ok = next_st.bus_driven_out && i_bus_grant_in;
		if (!i_bus_grant_in && !st.bus_driven_out)
			next_st.bus_request_out = i_core.core_bus_need;

		// external master sequence; a strobe is only taken while we do not drive the bus
		case (st.em)
			tbo_pkg::EM_IDLE: begin
				if (i_xfer_begin_strobe && !st.bus_driven_out) begin
					next_st.cap = i_xfer;
					if (!i_upper_addr_en)
						next_st.cap.addr[`TBO_UPPER_MSB:`TBO_UPPER_LSB] = `TBO_UPPER_ZERO;
					next_st.em = tbo_pkg::EM_DECODE;
				end
			end
			tbo_pkg::EM_DECODE: begin
				next_st.auto_ack = dec_auto;
				if (|cs_sel) begin
					next_st.mem.cs_n = ~cs_sel;
					if (st.cap.write)
						next_st.mem.we_n = ~lanes;
				end else if (|dram_sel) begin
					next_st.mem.ras_n        = ~dram_sel;
					next_st.mem.cas_n        = ~lanes;
					next_st.mem.dram_write_n = ~st.cap.write;
					next_st.mem.dram_addr_oe = dec_drive;
				end
				if (dec_auto) begin
					next_st.ack_oe = 1'b1;
					if (dec_wait == '0) begin
						next_st.ack_n = 1'b0;
						next_st.em    = tbo_pkg::EM_ACK;
					end else begin
						next_st.ack_n = 1'b1;
						next_st.cnt   = dec_wait;
						next_st.em    = tbo_pkg::EM_WAIT;
					end
				end else if ((|cs_sel) || (|dram_sel)) begin
					next_st.em = tbo_pkg::EM_WAIT;
				end else begin
					next_st.em = tbo_pkg::EM_IDLE;
				end
			end
			tbo_pkg::EM_WAIT: begin
				if (st.auto_ack) begin
					if (st.cnt <= `TBO_WAIT_W'(1)) begin
						next_st.ack_n = 1'b0;
						next_st.em    = tbo_pkg::EM_ACK;
					end else begin
						next_st.cnt = st.cnt - `TBO_WAIT_W'(1);
					end
				end else if (!i_xfer_ack_n_in) begin
					// another slave ended it; strobes drop with that ack
					next_st.mem = RST_STATE.mem;
					next_st.em  = tbo_pkg::EM_IDLE;
				end
			end
			tbo_pkg::EM_ACK: begin
				next_st.ack_n = 1'b1;
				next_st.mem   = RST_STATE.mem;
				next_st.em    = tbo_pkg::EM_RELEASE;
			end
			tbo_pkg::EM_RELEASE: begin
				next_st.ack_oe = 1'b0;
				next_st.em     = tbo_pkg::EM_IDLE;
			end
			default: next_st.em = tbo_pkg::EM_IDLE;
		endcase
		// in-flight external sequences are dropped by either reset
		if (resets) begin
			next_st.em     = tbo_pkg::EM_IDLE;
			next_st.mem    = RST_STATE.mem;
			next_st.ack_n  = 1'b1;
			next_st.ack_oe = 1'b0;
		end
	end

	// one register for all state
	// rising edge only
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n)
			st <= RST_STATE;
		else
			st <= next_st;
	end

	assign o_bus_driven_out  = st.bus_driven_out;
	assign o_bus_request_out = st.bus_request_out;
	assign o_bus_owner       = st.owner;
	assign o_xfer_start_ok   = st.start_ok;
	assign o_mem             = st.mem;
	assign o_xfer_ack_n      = st.ack_n;
	assign o_xfer_ack_oe     = st.ack_oe;

	// checks on ownership and external master sequencing
	property p_reset_entry;
		@(posedge i_sys_clk) disable iff (!rst_n)
		resets |=> (st.own == tbo_pkg::OWN_RESET) && !o_bus_driven_out;
	endproperty
	a_reset_entry: assert property (p_reset_entry) else $error("reset did not force reset state");
	property p_exit_grant;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(st.own == tbo_pkg::OWN_RESET) && !resets && i_bus_grant_in |=> o_bus_owner && !o_bus_driven_out;
	endproperty
	a_exit_grant: assert property (p_exit_grant) else $error("reset exit with grant not implicit");
	property p_exit_nogrant;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(st.own == tbo_pkg::OWN_RESET) && !resets && !i_bus_grant_in |=> st.own == tbo_pkg::OWN_EM;
	endproperty
	a_exit_nogrant: assert property (p_exit_nogrant) else $error("reset exit without grant wrong");
	property p_driven_only_explicit;
		@(posedge i_sys_clk) disable iff (!rst_n)
		o_bus_driven_out |-> o_bus_owner && (st.own == tbo_pkg::OWN_EXPLICIT);
	endproperty
	a_driven_only_explicit: assert property (p_driven_only_explicit) else $error("bus-driven outside explicit");
	property p_implicit_quiet;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(st.own == tbo_pkg::OWN_IMPLICIT) && !resets && i_bus_grant_in && !i_core.bus_lock
			&& !i_core.core_bus_need |=> !o_bus_driven_out && o_bus_owner;
	endproperty
	a_implicit_quiet: assert property (p_implicit_quiet) else $error("implicit own drove the bus");
	property p_go_explicit;
		@(posedge i_sys_clk) disable iff (!rst_n)
		!resets && i_bus_grant_in && (i_core.bus_lock || i_core.core_bus_need)
			&& (st.own != tbo_pkg::OWN_RESET) |=> o_bus_driven_out ##0 o_xfer_start_ok;
	endproperty
	a_go_explicit: assert property (p_go_explicit) else $error("no explicit own with grant and need");
	property p_grant_holds;
		@(posedge i_sys_clk) disable iff (!rst_n)
		o_bus_driven_out && i_bus_grant_in && !resets |=> o_bus_driven_out;
	endproperty
	a_grant_holds: assert property (p_grant_holds) else $error("explicit own lost under grant");
	property p_lock_holds;
		@(posedge i_sys_clk) disable iff (!rst_n)
		o_bus_driven_out && i_core.bus_lock && !resets |=> o_bus_driven_out;
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("bus-driven dropped with lock set");
	property p_release;
		@(posedge i_sys_clk) disable iff (!rst_n)
		o_bus_driven_out && !i_bus_grant_in && !i_core.bus_lock && i_core.cycle_busy && !i_core.cycle_end
			&& !resets ##1 !i_bus_grant_in && !i_core.bus_lock && i_core.cycle_end && !resets
			|-> o_bus_driven_out ##1 !o_bus_driven_out;
	endproperty
	a_release: assert property (p_release) else $error("bus not released at end of cycle");
	property p_request_copy;
		@(posedge i_sys_clk) disable iff (!rst_n)
		!i_bus_grant_in && !o_bus_driven_out |=> o_bus_request_out == $past(i_core.core_bus_need);
	endproperty
	a_request_copy: assert property (p_request_copy) else $error("bus request not registered need");
	property p_capture;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(st.em == tbo_pkg::EM_IDLE) && i_xfer_begin_strobe && !o_bus_driven_out && !resets
			|=> st.cap.addr[`TBO_UPPER_LSB-1:0] == $past(i_xfer.addr[`TBO_UPPER_LSB-1:0])
			&& st.cap.write == $past(i_xfer.write) && (st.em == tbo_pkg::EM_DECODE);
	endproperty
	a_capture: assert property (p_capture) else $error("transfer not captured on strobe");
	property p_decode_gap;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(st.em == tbo_pkg::EM_IDLE) && i_xfer_begin_strobe && !o_bus_driven_out
			|=> o_xfer_ack_n && (o_mem.cs_n == `TBO_RST_CS_N) && !o_xfer_ack_oe;
	endproperty
	a_decode_gap: assert property (p_decode_gap) else $error("memory control before decode clock");
	property p_ack_release;
		@(posedge i_sys_clk) disable iff (!rst_n)
		!o_xfer_ack_n && o_xfer_ack_oe && !resets |=> o_xfer_ack_n && o_xfer_ack_oe ##1 !o_xfer_ack_oe;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack not negated then released");

	c_explicit: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		(st.own == tbo_pkg::OWN_IMPLICIT) ##1 o_bus_driven_out);
	c_em_ack: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		(st.em == tbo_pkg::EM_DECODE) ##[1:20] !o_xfer_ack_n);
	c_lock_hold: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		o_bus_driven_out && !i_bus_grant_in && i_core.bus_lock ##1 o_bus_driven_out);
	c_refused: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		(st.em == tbo_pkg::EM_DECODE) && in_region && !(|cs_sel) && !(|dram_sel)); // region hit, wrong direction
endmodule // tbo_bus_own
`default_nettype wire

// ### logic/tbo_cfg.svh
/*
 tbo_cfg.svh: constants of the bus ownership and external master block.
 Assumes it is included by tbo_pkg and by the design modules by bare name.
*/
`ifndef TBO_CFG_SVH
`define TBO_CFG_SVH
`define TBO_ADDR_W     28
`define TBO_UPPER_MSB  27
`define TBO_UPPER_LSB  24
`define TBO_CMP_LSB    16
`define TBO_NUM_CS     8
`define TBO_NUM_DRAM   2
`define TBO_NUM_LANES  4
`define TBO_WAIT_W     4
`define TBO_SIZE_LONG  2'h0
`define TBO_SIZE_BYTE  2'h1
`define TBO_SIZE_WORD  2'h2
`define TBO_SIZE_LINE  2'h3
`define TBO_RST_CS_N   8'hFF
`define TBO_RST_LANE_N 4'hF
`define TBO_RST_RAS_N  2'h3
`define TBO_UPPER_ZERO 4'h0
`endif

// ### logic/tbo_pkg.sv
/*
 tbo_pkg: types of the bus ownership and external master block.
 Assumes tbo_cfg.svh is on the include path.
*/
`default_nettype none
package tbo_pkg;
`include "tbo_cfg.svh"

	typedef enum logic [1:0] {
		OWN_RESET    = 2'h0,
		OWN_EM       = 2'h1,
		OWN_IMPLICIT = 2'h2,
		OWN_EXPLICIT = 2'h3
	} tbo_own_t;

	typedef enum logic [2:0] {
		EM_IDLE    = 3'h0,
		EM_DECODE  = 3'h1,
		EM_WAIT    = 3'h2,
		EM_ACK     = 3'h3,
		EM_RELEASE = 3'h4
	} tbo_em_t;

	typedef struct packed {
		logic [`TBO_ADDR_W-1:0] addr;
		logic                   write;
		logic [1:0]             xfer_size;
	} tbo_cap_t;

	typedef struct packed {
		logic [`TBO_ADDR_W-`TBO_CMP_LSB-1:0] base;
		logic [`TBO_ADDR_W-`TBO_CMP_LSB-1:0] mask;
		logic                                rd_en;
		logic                                wr_en;
		logic                                ext_master_auto_ack;
		logic [`TBO_WAIT_W-1:0]              wait_count;
	} tbo_cs_cfg_t;

	typedef struct packed {
		logic [`TBO_ADDR_W-`TBO_CMP_LSB-1:0] base;
		logic [`TBO_ADDR_W-`TBO_CMP_LSB-1:0] mask;
		logic                                rd_en;
		logic                                wr_en;
		logic                                dram_addr_drive_en;
		logic [`TBO_WAIT_W-1:0]              wait_count;
	} tbo_dram_cfg_t;

	typedef struct packed {
		logic                   ext_master_auto_ack;
		logic [`TBO_WAIT_W-1:0] wait_count;
	} tbo_def_mem_t;

	typedef struct packed {
		logic core_bus_need;
		logic bus_lock;
		logic cycle_busy;
		logic cycle_end;
	} tbo_core_t;

	typedef struct packed {
		logic [`TBO_NUM_CS-1:0]    cs_n;
		logic [`TBO_NUM_LANES-1:0] we_n;
		logic [`TBO_NUM_DRAM-1:0]  ras_n;
		logic [`TBO_NUM_LANES-1:0] cas_n;
		logic                      dram_write_n;
		logic                      dram_addr_oe;
	} tbo_mem_t;

	typedef struct packed {
		tbo_own_t               own;
		logic                   bus_driven_out;
		logic                   bus_request_out;
		logic                   owner;
		logic                   start_ok;
		tbo_em_t                em;
		tbo_cap_t               cap;
		logic [`TBO_WAIT_W-1:0] cnt;
		logic                   auto_ack;
		tbo_mem_t               mem;
		logic                   ack_n;
		logic                   ack_oe;
	} tbo_state_t;
endpackage
`default_nettype wire

// ### logic/tbo_addr_decode.sv
/*
 tbo_addr_decode: decodes a captured external master address into a chip
 select, a DRAM bank or default memory, with the wait count and ack mode.
 Assumes the captured transfer is stable for the decode cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tbo_cfg.svh"
module tbo_addr_decode #(
	parameter int NUM_CS   = `TBO_NUM_CS,
	parameter int NUM_DRAM = `TBO_NUM_DRAM
) (
	input  wire tbo_pkg::tbo_cap_t      i_cap,
	input  wire tbo_pkg::tbo_cs_cfg_t   i_chip_sel_ctrl [NUM_CS],
	input  wire tbo_pkg::tbo_dram_cfg_t i_dram_ctrl_cfg [NUM_DRAM],
	input  wire tbo_pkg::tbo_def_mem_t  i_default_mem_ctrl,
	output logic [NUM_CS-1:0]           o_cs_sel,
	output logic [NUM_DRAM-1:0]         o_dram_sel,
	output logic                        o_in_region,
	output logic                        o_auto_ack,
	output logic                        o_dram_drive,
	output logic [`TBO_WAIT_W-1:0]      o_wait
);
	logic [`TBO_ADDR_W-`TBO_CMP_LSB-1:0] hi;
	logic [NUM_CS-1:0]                   cs_match;
	logic [NUM_CS-1:0]                   cs_ok;
	logic [NUM_DRAM-1:0]                 dr_match;
	logic [NUM_DRAM-1:0]                 dr_ok;

	assign hi = i_cap.addr[`TBO_ADDR_W-1:`TBO_CMP_LSB];

	// per select compare; privilege and space masks do not exist here
	// space masks ignored
	genvar g;
	generate
		for (g = 0; g < NUM_CS + NUM_DRAM; g++) begin : g_cmp
			if (g < NUM_CS) begin : g_cs
				assign cs_match[g] = (((hi ^ i_chip_sel_ctrl[g].base) & ~i_chip_sel_ctrl[g].mask) == '0)
					&& (i_chip_sel_ctrl[g].rd_en || i_chip_sel_ctrl[g].wr_en);
				assign cs_ok[g] = cs_match[g] && (i_cap.write ? i_chip_sel_ctrl[g].wr_en
					: i_chip_sel_ctrl[g].rd_en);
			end else begin : g_dr
				localparam int D = g - NUM_CS;
				assign dr_match[D] = (((hi ^ i_dram_ctrl_cfg[D].base) & ~i_dram_ctrl_cfg[D].mask) == '0)
					&& (i_dram_ctrl_cfg[D].rd_en || i_dram_ctrl_cfg[D].wr_en);
				assign dr_ok[D] = dr_match[D] && (i_cap.write ? i_dram_ctrl_cfg[D].wr_en
					: i_dram_ctrl_cfg[D].rd_en);
			end
		end
	endgenerate

	// lowest index wins; chip selects take priority over DRAM
	always_comb begin
		o_cs_sel     = '0;
		o_dram_sel   = '0;
		o_in_region  = (|cs_match) || (|dr_match);
		o_auto_ack   = i_default_mem_ctrl.ext_master_auto_ack;
		o_dram_drive = 1'b0;
		o_wait       = i_default_mem_ctrl.wait_count;
		if (|cs_match) begin
			o_auto_ack = 1'b0;
			for (int i = NUM_CS - 1; i >= 0; i--) begin
				if (cs_ok[i]) begin
					o_cs_sel   = '0;
					o_cs_sel[i] = 1'b1;
					o_auto_ack = i_chip_sel_ctrl[i].ext_master_auto_ack;
					o_wait     = i_chip_sel_ctrl[i].wait_count;
				end
			end
		end else if (|dr_match) begin
			o_auto_ack = 1'b0;
			for (int i = NUM_DRAM - 1; i >= 0; i--) begin
				if (dr_ok[i]) begin
					o_dram_sel    = '0;
					o_dram_sel[i] = 1'b1;
					o_auto_ack    = 1'b1;
					o_dram_drive  = i_dram_ctrl_cfg[i].dram_addr_drive_en;
					o_wait        = i_dram_ctrl_cfg[i].wait_count;
				end
			end
		end
	end
endmodule // tbo_addr_decode
`default_nettype wire

// ### verif/tbo_far_side.sv
/*
 tbo_far_side: external arbiter and external master facing the block.
 Assumes the bench calls its tasks from one process, at clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
module tbo_far_side (
	input  wire logic         i_sys_clk,
	input  wire logic         i_bus_driven,
	input  wire logic         i_ack_n,
	input  wire logic         i_ack_oe,
	output logic              o_grant,
	output logic              o_strobe,
	output tbo_pkg::tbo_cap_t o_xfer,
	output logic              o_ack_wire
);
	logic slave_ack_n; // another slave's ack, low while it ends a cycle

	// ack wire has a pull-up, so a released pin reads negated unless another slave pulls it
	assign o_ack_wire = i_ack_oe ? i_ack_n : slave_ack_n;

	// idle arbiter and master at time zero
	initial begin
		o_grant = 1'h0;
		o_strobe = 1'h0;
		o_xfer = '0;
		slave_ack_n = 1'h1;
	end

	task automatic set_grant(input logic v);
		@(posedge i_sys_clk);
		o_grant <= v;
	endtask

	// aligned, start only while bus not ours
	task automatic issue(input tbo_pkg::tbo_cap_t x);
		@(posedge i_sys_clk);
		o_strobe <= ~i_bus_driven;
		o_xfer <= x;
		@(posedge i_sys_clk);
		o_strobe <= 1'h0;
		o_xfer <= ~x; // released lines do not keep the old value
	endtask

	// a slave outside the block terminates a cycle that the block does not ack
	task automatic slave_ack();
		@(posedge i_sys_clk);
		slave_ack_n <= 1'h0;
		@(posedge i_sys_clk);
		slave_ack_n <= 1'h1;
	endtask
endmodule // tbo_far_side
`default_nettype wire

// ### verif/tb.sv
/*
 tb: self-checking bench for tbo_bus_own with the far side model.
 Assumes logic/ is on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tbo_cfg.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
	logic                   clk, reset_n, hard, wdog, grant, strobe, ack_wire, upper_en;
	logic                   bd, req, owner, start_ok, ack_n, ack_oe;
	tbo_pkg::tbo_core_t     core;
	tbo_pkg::tbo_cap_t      xfer;
	tbo_pkg::tbo_cs_cfg_t   cs_cfg [`TBO_NUM_CS];
	tbo_pkg::tbo_dram_cfg_t dram_cfg [`TBO_NUM_DRAM];
	tbo_pkg::tbo_def_mem_t  def_cfg;
	tbo_pkg::tbo_mem_t      mem;
	int                     fails, samples_checked;

	tbo_bus_own tbo_bus_own_inst (.i_sys_clk(clk), .i_reset_n(reset_n), .i_hard_reset_in(hard), .i_wdog_reset(wdog),
		.i_bus_grant_in(grant), .i_core(core), .i_upper_addr_en(upper_en), .i_xfer_begin_strobe(strobe),
		.i_xfer(xfer), .i_xfer_ack_n_in(ack_wire), .i_chip_sel_ctrl(cs_cfg), .i_dram_ctrl_cfg(dram_cfg),
		.i_default_mem_ctrl(def_cfg), .o_bus_driven_out(bd), .o_bus_request_out(req), .o_bus_owner(owner),
		.o_xfer_start_ok(start_ok), .o_mem(mem), .o_xfer_ack_n(ack_n), .o_xfer_ack_oe(ack_oe));
	tbo_far_side tbo_far_side_inst (.i_sys_clk(clk), .i_bus_driven(bd), .i_ack_n(ack_n), .i_ack_oe(ack_oe),
		.o_grant(grant), .o_strobe(strobe), .o_xfer(xfer), .o_ack_wire(ack_wire));

	// 100 MHz clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// sample 1 ns after the edge so the edge's updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// external master transfer; returns just after the edge after decode
	task automatic ext(input logic [27:0] a, input logic w, input logic [1:0] sz);
		tbo_far_side_inst.issue('{addr: a, write: w, xfer_size: sz});
		tick(1);
	endtask

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog: the tests need well under a thousand cycles
	initial begin
		#20000;
		fails++;
		results();
	end

	// main sequence
	initial begin
		reset_n = 1'h0;
		hard = 1'h0;
		wdog = 1'h0;
		core = '0;
		upper_en = 1'h1;
		fails = 0;
		samples_checked = 0;
		foreach (cs_cfg[i]) cs_cfg[i] = '0;
		foreach (dram_cfg[i]) dram_cfg[i] = '0;
		cs_cfg[0] = '{base: 12'h001, mask: 12'h000, rd_en: 1'h1, wr_en: 1'h1, ext_master_auto_ack: 1'h1, wait_count: 4'h0};
		dram_cfg[0] = '{base: 12'h002, mask: 12'h000, rd_en: 1'h1, wr_en: 1'h1, dram_addr_drive_en: 1'h1, wait_count: 4'h0};
		def_cfg = '{ext_master_auto_ack: 1'h1, wait_count: 4'h2};
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		tick(3);
		`CHK("owner", 1'h0, owner)
		`CHK("driven", 1'h0, bd)
		@(posedge clk);
		core.core_bus_need <= 1'h1;
		tick(1);
		`CHK("request", 1'h1, req)
		tbo_far_side_inst.set_grant(1'h1);
		tick(1);
		`CHK("driven", 1'h1, bd)
		`CHK("start_ok", 1'h1, start_ok)
		@(posedge clk);
		core.core_bus_need <= 1'h0;
		tick(3);
		`CHK("driven", 1'h1, bd)
		tbo_far_side_inst.set_grant(1'h0);
		core.cycle_busy <= 1'h1;
		tick(3);
		`CHK("driven", 1'h1, bd)
		@(posedge clk);
		core.cycle_end <= 1'h1;
		@(posedge clk);
		core <= '0;
		#1;
		`CHK("driven", 1'h0, bd)
		`CHK("owner", 1'h0, owner)
		$display("test release done");
		// lock held past loss of grant
		tbo_far_side_inst.set_grant(1'h1);
		core.bus_lock <= 1'h1;
		tick(1);
		`CHK("driven", 1'h1, bd)
		tbo_far_side_inst.set_grant(1'h0);
		tick(3);
		`CHK("driven", 1'h1, bd)
		@(posedge clk);
		core.bus_lock <= 1'h0;
		tick(1);
		`CHK("driven", 1'h0, bd)
		$display("test lock done");
		// watchdog reset then hard reset, grant held
		for (int k = 0; k < 2; k++) begin
			tbo_far_side_inst.set_grant(1'h1);
			{hard, wdog} <= 2'h1 << k;
			@(posedge clk);
			{hard, wdog} <= 2'h0;
			#1;
			`CHK("owner", 1'h0, owner)
			tick(2);
			`CHK("owner", 1'h1, owner)
			`CHK("driven", 1'h0, bd)
		end
		@(posedge clk);
		core.core_bus_need <= 1'h1;
		tick(1);
		`CHK("driven", 1'h1, bd)
		tbo_far_side_inst.set_grant(1'h0);
		core <= '0;
		tick(1);
		`CHK("driven", 1'h0, bd)
		$display("test resets done");
		// chip select read, auto ack with no wait; upper bits masked in turn
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			upper_en <= k[0] ? 1'h0 : 1'h1;
			ext(k[0] ? 28'hA010000 : 28'h0010000, 1'h0, `TBO_SIZE_LONG);
			`CHK("cs_n", 8'hFE, mem.cs_n)
			`CHK("ack", 2'h2, {ack_oe, ack_n})
			tick(1);
			`CHK("ack", 2'h3, {ack_oe, ack_n})
			`CHK("cs_n", 8'hFF, mem.cs_n)
			tick(1);
			`CHK("ack_oe", 1'h0, ack_oe)
		end
		$display("test chip select done");
		ext(28'h0300000, 1'h0, `TBO_SIZE_LONG);
		`CHK("ack", 2'h3, {ack_oe, ack_n})
		tick(2);
		`CHK("ack", 2'h2, {ack_oe, ack_n})
		`CHK("cs_n", 8'hFF, mem.cs_n)
		tick(2);
		ext(28'h0020000, 1'h1, `TBO_SIZE_LONG);
		`CHK("dram", 8'h81, {mem.ras_n, mem.cas_n, mem.dram_write_n, mem.dram_addr_oe})
		`CHK("ack", 2'h2, {ack_oe, ack_n})
		tick(2);
		`CHK("ack_oe", 1'h0, ack_oe)
		$display("test memory done");
		// byte write to a select without auto ack: strobes stand until another slave acks
		@(posedge clk);
		cs_cfg[0].ext_master_auto_ack <= 1'h0;
		ext(28'h0010001, 1'h1, `TBO_SIZE_BYTE);
		`CHK("cs_we", 12'hFEB, {mem.cs_n, mem.we_n})
		`CHK("ack_oe", 1'h0, ack_oe)
		tick(1);
		`CHK("cs_we", 12'hFEB, {mem.cs_n, mem.we_n})
		tbo_far_side_inst.slave_ack();
		tick(0);
		`CHK("cs_we", 12'hFFF, {mem.cs_n, mem.we_n})
		$display("test slave ack done");
		// refused direction, default memory without auto ack, DRAM read without address drive
		@(posedge clk);
		cs_cfg[0].wr_en <= 1'h0;
		def_cfg.ext_master_auto_ack <= 1'h0;
		dram_cfg[0].dram_addr_drive_en <= 1'h0;
		ext(28'h0010000, 1'h1, `TBO_SIZE_LONG);
		`CHK("cs_we", 12'hFFF, {mem.cs_n, mem.we_n})
		`CHK("ack_oe", 1'h0, ack_oe)
		ext(28'h0300000, 1'h0, `TBO_SIZE_LONG);
		`CHK("ack", 2'h1, {ack_oe, ack_n})
		tick(2);
		`CHK("ack", 2'h1, {ack_oe, ack_n})
		ext(28'h0020000, 1'h0, `TBO_SIZE_LONG);
		`CHK("dram", 8'h82, {mem.ras_n, mem.cas_n, mem.dram_write_n, mem.dram_addr_oe})
		`CHK("ack", 2'h2, {ack_oe, ack_n})
		tick(2);
		`CHK("ack_oe", 1'h0, ack_oe)
		$display("test refusals done");
		results();
	end
endmodule // tb
`default_nettype wire
